/* File: irq_regs_pkg.sv */
// Package with register map, field layout and reset values of the interrupt flag/priority block
package irq_regs_pkg;

  // Register word offsets (16-bit registers; the two priority registers four bytes apart)
  localparam logic [7:0] FLAG_STATUS_TWO_OFS = 8'h88;
  localparam logic [7:0] PRIO_CTRL_ZERO_OFS  = 8'ha4;
  localparam logic [7:0] PRIO_CTRL_TWO_OFS   = 8'ha8;

  // Flag positions in the second flag status register
  localparam int CAN_ONE_RX_READY_POS = 2;
  localparam int SPI_TWO_EVENT_POS    = 1;
  localparam int SPI_TWO_ERROR_POS    = 0;

  // Priority field low-bit positions (fields are three bits wide)
  localparam int PRIO_FIELD_W = 3;
  localparam int PRIO_F3_POS  = 12;
  localparam int PRIO_F2_POS  = 8;
  localparam int PRIO_F1_POS  = 4;
  localparam int PRIO_F0_POS  = 0;

  // Reset values
  localparam logic [15:0] FLAG_STATUS_RESET = 16'h0000;
  localparam logic [2:0]  PRIO_FIELD_RESET  = 3'h4;
  localparam logic [2:0]  PRIO_DISABLED     = 3'h0;

  // Implemented-bit masks
  localparam logic [15:0] FLAG_STATUS_MASK = 16'h0007;
  localparam logic [15:0] PRIO_CTRL_MASK   = 16'h7777;

  // Per-source request to the CPU arbitration: active level and priority
  typedef struct packed {
    logic       req;
    logic [2:0] level;
  } irq_req_t;

endpackage

/* File: irq_flag_priority_regs.sv */
// Interrupt flag status bits and two priority control registers
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps

// Overview of operation
// - CAN one receive-ready flag at bit 2
// - SPI two event flag at bit 1
// - SPI two error flag at bit 0
// - Priority field value equals level, 7 highest
// - Value 1 lowest level, 0 disables source
// - Unimplemented bits read as zero
module irq_flag_priority_regs (
  // Clock and reset
  input  wire logic                   CLK,
  input  wire logic                   SRST,
  // Register port
  input  wire logic [7:0]             ADDR,
  input  wire logic [15:0]            WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [15:0]            RDATA,
  // Peripheral event pulses (same clock domain)
  input  wire logic                   CAN_ONE_RX_EVT,
  input  wire logic                   SPI_TWO_EVT,
  input  wire logic                   SPI_TWO_ERR_EVT,
  // Requests to CPU arbitration, one per source with priority level
  output irq_regs_pkg::irq_req_t      CAN_ONE_RX_REQ,
  output irq_regs_pkg::irq_req_t      SPI_TWO_EVT_REQ,
  output irq_regs_pkg::irq_req_t      SPI_TWO_ERR_REQ,
  // Priority levels of the eight priority-register sources (0 = disabled)
  output logic      [2:0]             TIMER_ONE_PRIORITY,
  output logic      [2:0]             OUT_COMPARE_ONE_PRIORITY,
  output logic      [2:0]             IN_CAPTURE_ONE_PRIORITY,
  output logic      [2:0]             EXT_IRQ_ZERO_PRIORITY,
  output logic      [2:0]             UART_ONE_RX_PRIORITY,
  output logic      [2:0]             SPI_ONE_EVENT_PRIORITY,
  output logic      [2:0]             SPI_ONE_ERROR_PRIORITY,
  output logic      [2:0]             TIMER_THREE_PRIORITY
);

  localparam logic [15:0] PRIO_RESET_WORD =
    {1'b0, irq_regs_pkg::PRIO_FIELD_RESET, 1'b0, irq_regs_pkg::PRIO_FIELD_RESET,
     1'b0, irq_regs_pkg::PRIO_FIELD_RESET, 1'b0, irq_regs_pkg::PRIO_FIELD_RESET};

  logic [2:0]  flags_q;
  logic [2:0]  flags_d;
  logic [15:0] prio0_q;
  logic [15:0] prio0_d;
  logic [15:0] prio2_q;
  logic [15:0] prio2_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [2:0]  evt;
  logic        wr_flags;
  logic [2:0]  wdata_hi_field;
  logic [2:0]  wdata_lo_field;

  assign evt = {CAN_ONE_RX_EVT, SPI_TWO_EVT, SPI_TWO_ERR_EVT};
  assign wr_flags = WR && (ADDR == irq_regs_pkg::FLAG_STATUS_TWO_OFS);

  // Write data slices, named so the checks can look back at them
  assign wdata_hi_field = WDATA[14:12];
  assign wdata_lo_field = WDATA[2:0];

  // Flags: software write sets or clears, but an event in the same cycle wins
  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = WDATA[2:0];
    end
    flags_d = flags_d | evt;
  end

  // Priority registers: only implemented field bits are stored
  always_comb begin
    prio0_d = prio0_q;
    prio2_d = prio2_q;
    if (WR && ADDR == irq_regs_pkg::PRIO_CTRL_ZERO_OFS) begin
      prio0_d = WDATA & irq_regs_pkg::PRIO_CTRL_MASK;
    end else if (WR && ADDR == irq_regs_pkg::PRIO_CTRL_TWO_OFS) begin
      prio2_d = WDATA & irq_regs_pkg::PRIO_CTRL_MASK;
    end
  end

  // Read mux; unmapped addresses and reserved bits read as zero
  always_comb begin
    rdata_d = 16'h0000;
    if (RD && ADDR == irq_regs_pkg::FLAG_STATUS_TWO_OFS) begin
      rdata_d = {13'h0, flags_q};
    end else if (RD && ADDR == irq_regs_pkg::PRIO_CTRL_ZERO_OFS) begin
      rdata_d = prio0_q;
    end else if (RD && ADDR == irq_regs_pkg::PRIO_CTRL_TWO_OFS) begin
      rdata_d = prio2_q;
    end
  end

  // Flag register; reset clears pending requests so none leak past a restart
  always_ff @(posedge CLK) begin
    if (SRST) begin
      flags_q <= irq_regs_pkg::FLAG_STATUS_RESET[2:0];
    end else begin
      flags_q <= flags_d;
    end
  end

  // Priority registers; mid level after reset keeps every source live
  always_ff @(posedge CLK) begin
    if (SRST) begin
      prio0_q <= PRIO_RESET_WORD;
      prio2_q <= PRIO_RESET_WORD;
    end else begin
      prio0_q <= prio0_d;
      prio2_q <= prio2_d;
    end
  end

  // Read data register; holds a value in each cycle after one with RD high, zero otherwise
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;

  // Field extraction; the level is the field value as stored
  assign TIMER_ONE_PRIORITY       = prio0_q[14:12];
  assign OUT_COMPARE_ONE_PRIORITY = prio0_q[10:8];
  assign IN_CAPTURE_ONE_PRIORITY  = prio0_q[6:4];
  assign EXT_IRQ_ZERO_PRIORITY    = prio0_q[2:0];
  assign UART_ONE_RX_PRIORITY     = prio2_q[14:12];
  assign SPI_ONE_EVENT_PRIORITY   = prio2_q[10:8];
  assign SPI_ONE_ERROR_PRIORITY   = prio2_q[6:4];
  assign TIMER_THREE_PRIORITY     = prio2_q[2:0];

  // Flag sources have no priority field here, so they request at the reset level.
  // A disabled level would gate them; kept so a future field drops in directly.
  always_comb begin
    CAN_ONE_RX_REQ.level  = irq_regs_pkg::PRIO_FIELD_RESET;
    SPI_TWO_EVT_REQ.level = irq_regs_pkg::PRIO_FIELD_RESET;
    SPI_TWO_ERR_REQ.level = irq_regs_pkg::PRIO_FIELD_RESET;
    CAN_ONE_RX_REQ.req  = flags_q[irq_regs_pkg::CAN_ONE_RX_READY_POS] &&
                          (CAN_ONE_RX_REQ.level != irq_regs_pkg::PRIO_DISABLED);
    SPI_TWO_EVT_REQ.req = flags_q[irq_regs_pkg::SPI_TWO_EVENT_POS] &&
                          (SPI_TWO_EVT_REQ.level != irq_regs_pkg::PRIO_DISABLED);
    SPI_TWO_ERR_REQ.req = flags_q[irq_regs_pkg::SPI_TWO_ERROR_POS] &&
                          (SPI_TWO_ERR_REQ.level != irq_regs_pkg::PRIO_DISABLED);
  end

  // Checks
  property p_can_flag_set;
    @(posedge CLK) disable iff (SRST) CAN_ONE_RX_EVT |=> flags_q[2];
  endproperty
  a_can_flag_set: assert property (p_can_flag_set) else $error("CAN flag not set");

  property p_spi_evt_flag;
    @(posedge CLK) disable iff (SRST) SPI_TWO_EVT |=> flags_q[1];
  endproperty
  a_spi_evt_flag: assert property (p_spi_evt_flag) else $error("SPI event flag not set");

  property p_spi_err_flag;
    @(posedge CLK) disable iff (SRST)
      (RD && ADDR == irq_regs_pkg::FLAG_STATUS_TWO_OFS && flags_q[0]) |=> RDATA[0];
  endproperty
  a_spi_err_flag: assert property (p_spi_err_flag) else $error("SPI error flag misread");

  property p_prio_level;
    @(posedge CLK) disable iff (SRST)
      (WR && ADDR == irq_regs_pkg::PRIO_CTRL_ZERO_OFS) |=>
        TIMER_ONE_PRIORITY == $past(wdata_hi_field);
  endproperty
  a_prio_level: assert property (p_prio_level) else $error("Priority level mismatch");

  property p_disabled_no_req;
    @(posedge CLK) disable iff (SRST)
      CAN_ONE_RX_REQ.req |-> CAN_ONE_RX_REQ.level != 3'h0 && flags_q[2];
  endproperty
  a_disabled_no_req: assert property (p_disabled_no_req) else $error("Request while off");

  property p_field_pos;
    @(posedge CLK) disable iff (SRST)
      (RD && ADDR == irq_regs_pkg::PRIO_CTRL_ZERO_OFS) |=>
        RDATA[2:0] == EXT_IRQ_ZERO_PRIORITY && RDATA[6:4] == IN_CAPTURE_ONE_PRIORITY;
  endproperty
  a_field_pos: assert property (p_field_pos) else $error("Field position wrong");

  property p_reserved_zero;
    @(posedge CLK) disable iff (SRST) (RDATA & 16'h8888) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set");

  property p_reset_level;
    @(posedge CLK) $fell(SRST) |-> TIMER_THREE_PRIORITY == 3'h4 && EXT_IRQ_ZERO_PRIORITY == 3'h4;
  endproperty
  a_reset_level: assert property (p_reset_level) else $error("Reset level not four");

  // An event must survive a clearing write in the same cycle
  property p_spi_evt_wins;
    @(posedge CLK) disable iff (SRST) (SPI_TWO_EVT && wr_flags) |=> SPI_TWO_EVT_REQ.req;
  endproperty
  a_spi_evt_wins: assert property (p_spi_evt_wins) else $error("Clear beat event");

  property p_err_req_set;
    @(posedge CLK) disable iff (SRST) SPI_TWO_ERR_EVT |=> SPI_TWO_ERR_REQ.req;
  endproperty
  a_err_req_set: assert property (p_err_req_set) else $error("Error request missing");

  property p_flag_store;
    @(posedge CLK) disable iff (SRST)
      (wr_flags && evt == 3'h0) |=> flags_q == $past(wdata_lo_field);
  endproperty
  a_flag_store: assert property (p_flag_store) else $error("Flag write lost");

  property p_rdata_idle;
    @(posedge CLK) disable iff (SRST) !RD |=> RDATA == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data held");

  property p_flag_upper_zero;
    @(posedge CLK) disable iff (SRST)
      (RD && ADDR == irq_regs_pkg::FLAG_STATUS_TWO_OFS) |=> RDATA[15:3] == 13'h0;
  endproperty
  a_flag_upper_zero: assert property (p_flag_upper_zero) else $error("Flag upper set");

  property p_prio2_level;
    @(posedge CLK) disable iff (SRST)
      (WR && ADDR == irq_regs_pkg::PRIO_CTRL_TWO_OFS) |=>
        TIMER_THREE_PRIORITY == $past(wdata_lo_field);
  endproperty
  a_prio2_level: assert property (p_prio2_level) else $error("Second level mismatch");

endmodule

/* File: irq_event_model.sv */
// Model of the peripheral event sources that pulse the flag inputs
`timescale 1ns/1ps
module irq_event_model (
  // Clock and command from the bench
  input  wire logic       clk,
  input  wire logic [2:0] fire,
  // Event pulses, bit 2 CAN receive, bit 1 SPI event, bit 0 SPI error
  output logic      [2:0] evt
);
  // Registered so each pulse is clean and lasts as long as the fire command, as a peripheral strobe
  always_ff @(posedge clk) begin
    evt <= fire;
  end
endmodule

/* File: irq_flag_priority_regs_bench.sv */
// Self-checking bench for the interrupt flag and priority registers
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module irq_flag_priority_regs_bench;
  logic                   clk = 1'b0;
  logic                   srst = 1'b1;
  logic                   wr = 1'b0;
  logic                   rd = 1'b0;
  logic [7:0]             addr = 8'h00;
  logic [15:0]            wdata = 16'h0000;
  logic [15:0]            rdata;
  logic [2:0]             fire = 3'h0;
  logic [2:0]             evt;
  irq_regs_pkg::irq_req_t can_req;
  irq_regs_pkg::irq_req_t spi_req;
  irq_regs_pkg::irq_req_t err_req;
  logic [2:0]             p [8];
  int                     err_total = 0;
  int                     checks_done = 0;

  irq_event_model SRC (.clk(clk), .fire(fire), .evt(evt));
  irq_flag_priority_regs DUT (
    .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .CAN_ONE_RX_EVT(evt[2]), .SPI_TWO_EVT(evt[1]), .SPI_TWO_ERR_EVT(evt[0]),
    .CAN_ONE_RX_REQ(can_req), .SPI_TWO_EVT_REQ(spi_req), .SPI_TWO_ERR_REQ(err_req),
    .TIMER_ONE_PRIORITY(p[0]), .OUT_COMPARE_ONE_PRIORITY(p[1]),
    .IN_CAPTURE_ONE_PRIORITY(p[2]), .EXT_IRQ_ZERO_PRIORITY(p[3]),
    .UART_ONE_RX_PRIORITY(p[4]), .SPI_ONE_EVENT_PRIORITY(p[5]),
    .SPI_ONE_ERROR_PRIORITY(p[6]), .TIMER_THREE_PRIORITY(p[7]));

  // Clock of 50 ns period
  initial forever #25 clk = ~clk;

  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask

  // Reset image of all three registers and the outputs
  task automatic t_reset();
    rd_reg(8'h88, 16'h0000);
    rd_reg(8'ha4, 16'h4444);
    rd_reg(8'ha8, 16'h4444);
    for (int i = 0; i < 8; i++) `CHK("prio", 3'h4, p[i])
    `CHK("req", 3'h0, {can_req.req, spi_req.req, err_req.req})
    `CHK("level", {3{irq_regs_pkg::PRIO_FIELD_RESET}}, {can_req.level, spi_req.level, err_req.level})
  endtask

  // Each source sets only its own flag bit, then software clears it
  task automatic t_flags();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      fire <= 3'(1 << i);
      @(posedge clk);
      fire <= 3'h0;
      @(posedge clk);
      #1 `CHK("req", 3'(1 << i), {can_req.req, spi_req.req, err_req.req})
      rd_reg(8'h88, 16'(1 << i));
      wr_reg(8'h88, 16'h0000);
      rd_reg(8'h88, 16'h0000);
    end
  endtask

  // Field placement, reserved bits and an unmapped address
  task automatic t_prio();
    wr_reg(8'ha4, 16'hffff);
    rd_reg(8'ha4, 16'h7777);
    `CHK("prio", 3'h7, p[0])
    wr_reg(8'ha4, 16'h0123);
    wr_reg(8'ha8, 16'h4567);
    wr_reg(8'h90, 16'hffff);
    rd_reg(8'h90, 16'h0000);
    rd_reg(8'ha4, 16'h0123);
    rd_reg(8'ha8, 16'h4567);
    for (int i = 0; i < 8; i++) `CHK("prio", 3'(i), p[i])
  endtask

  // Event lands with a clearing write: the event wins; software may set flags too
  task automatic t_race();
    @(posedge clk);
    fire <= 3'h2;
    @(posedge clk);
    fire <= 3'h0;
    wr <= 1'b1;
    addr <= 8'h88;
    wdata <= 16'h0000;
    @(posedge clk);
    wr <= 1'b0;
    rd_reg(8'h88, 16'h0002);
    @(posedge clk);
    #1 `CHK("rdata idle", 16'h0000, rdata)
    wr_reg(8'h88, 16'h0005);
    #1 `CHK("req", 3'h5, {can_req.req, spi_req.req, err_req.req})
    rd_reg(8'h88, 16'h0005);
    wr_reg(8'h88, 16'h0000);
    rd_reg(8'h88, 16'h0000);
  endtask

  // Reset in mid-run brings back the reset image
  task automatic t_rerun();
    wr_reg(8'ha8, 16'h7070);
    wr_reg(8'h88, 16'h0007);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd_reg(8'h88, 16'h0000);
    rd_reg(8'ha8, 16'h4444);
    `CHK("prio", 3'h4, p[4])
    `CHK("req", 3'h0, {can_req.req, spi_req.req, err_req.req})
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_flags();
    t_race();
    t_prio();
    t_rerun();
    summarize();
  end

  // Watchdog far beyond the under a hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule
